// [sim/asi_serial_peer.sv]
// Purpose: far-side serial equipment, frame sender and frame catcher
// Assumes: fixed cycles per bit, receive line idles high
// Notes: caught frames queue up as {stop, data}, a bad start bit gives 3ff
`timescale 1ns/1ps

module asi_serial_peer
  import asi_pkg::*;
#(
  parameter int BIT_CYC = 32
)(
  // clock
  input wire logic sys_clk,
  // device transmit pin
  input wire logic tx_out,
  input wire logic tx_oe,
  // device receive pin
  output logic rx_line
);
  logic [9:0] got_q[$];
  logic [9:0] v;
  logic s0;
  int nbits = 8;
  int i;

  // line rests at mark level
  initial rx_line = 1'b1;

  // send start, data lsb first, stop; nz picks a bit to glitch
  task automatic send(input logic [8:0] w, input int nb, input logic stp, input int nz);
    logic b;
    // one bit time of idle line ahead of every frame
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int j = 0; j <= nb + 1; j++) begin
      b = (j == 0) ? 1'b0 : (j <= nb) ? w[j-1] : stp;
      for (int c = 0; c < BIT_CYC; c++) begin
        rx_line <= (j == nz && c >= 16 && c < 18) ? ~b : b;
        @(posedge sys_clk);
      end
    end
    rx_line <= 1'b1;
    @(posedge sys_clk);
  endtask

  // catch frames from the device pin at mid bit
  initial forever begin
    @(negedge tx_out iff tx_oe);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    s0 = tx_out;
    v = '0;
    for (i = 0; i <= nbits; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      if (i < nbits) v[i] = tx_out;
      else v[9] = tx_out;
    end
    got_q.push_back(s0 === 1'b0 ? v : 10'h3ff);
  end
endmodule

// [sim/asi_top_bench.sv]
// Purpose: self-checking bench of the async serial interface
// Assumes: baud code 00 gives 32 cycles per bit
// Notes: register tasks leave one quiet cycle after each strobe
`timescale 1ns/1ps

module asi_top_bench
  import asi_pkg::*;
;
  logic sys_clk;
  logic resetn;
  asi_bus_s bus_req;
  logic [7:0] rdata;
  logic tx_out;
  logic tx_oe;
  logic rx_line;
  logic cpu_irq_mask;
  logic irq;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  int k;
  int lo;
  logic [7:0] d;
  logic [7:0] br_tab [4] = '{8'h40, 8'h08, 8'hc0, 8'h80};
  int bit_tab [4] = '{96, 64, 416, 128};
  logic [7:0] rst_tab [5] = '{STATUS_RST, BAUD_RST, CTLA_RST, CTLB_RST, 8'h00};
  logic [2:0] adr_tab [5] = '{ADDR_STATUS, ADDR_BAUD, ADDR_CTLA, ADDR_CTLB, 3'h5};

  asi_top asi_top_inst (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .tx_out(tx_out),
    .tx_oe(tx_oe), .rx_serial_in(rx_line), .cpu_irq_mask(cpu_irq_mask), .irq(irq));
  asi_serial_peer asi_serial_peer_inst (.sys_clk(sys_clk), .tx_out(tx_out), .tx_oe(tx_oe), .rx_line(rx_line));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    bus_req <= '{1'b1, 1'b0, a, w};
    @(posedge sys_clk);
    bus_req <= '0;
    @(posedge sys_clk);
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 r = rdata;
    @(posedge sys_clk);
  endtask

  task automatic wait_words(input int n);
    for (int j = 0; j < 4000 && asi_serial_peer_inst.got_q.size() < n; j++) @(posedge sys_clk);
  endtask

  // status snapshot then data read
  task automatic rx_chk(input logic [7:0] st, input logic [7:0] dat);
    rd(ADDR_STATUS, d);
    chk("rx status", 10'(d & RX_FLAGS), 10'(st));
    rd(ADDR_DATA, d);
    chk("rx data", 10'(d), 10'(dat));
  endtask

  task automatic rx_case(input logic [8:0] w, input logic stp, input int nz, input logic [7:0] st);
    asi_serial_peer_inst.send(w, 8, stp, nz);
    repeat (20) @(posedge sys_clk);
    rx_chk(st, w[7:0]);
  endtask

  initial begin
    resetn = 1'b0;
    bus_req = '0;
    cpu_irq_mask = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // reset values and an unmapped index
    for (k = 0; k < 5; k++) begin
      rd(adr_tab[k], d);
      chk("reset reg", 10'(d), 10'(rst_tab[k]));
    end
    chk("pin off", 10'({tx_oe, tx_out, irq}), 10'h002);
    $display("test reset done");
    // enable sends idle first, data waits behind it
    t0 = cyc;
    wr(ADDR_CTLB, 8'h08);
    chk("pin on", 10'({tx_oe, tx_out}), 10'h003);
    rd(ADDR_STATUS, d);
    wr(ADDR_DATA, 8'ha5);
    rd(ADDR_STATUS, d);
    chk("held flags", 10'(d & TX_FLAGS), 10'h000);
    wait_words(1);
    chk("idle first", 10'(cyc - t0 > 560), 10'h001);
    chk("first word", asi_serial_peer_inst.got_q.pop_front(), 10'h2a5);
    repeat (40) @(posedge sys_clk);
    rd(ADDR_STATUS, d);
    chk("done flags", 10'(d), 10'(STATUS_RST));
    $display("test enable done");
    // quiet write goes straight out, next one is held
    wr(ADDR_DATA, 8'h3c);
    rd(ADDR_STATUS, d);
    chk("direct flags", 10'(d & TX_FLAGS), 10'h080);
    wr(ADDR_DATA, 8'hc3);
    wait_words(2);
    chk("word a", asi_serial_peer_inst.got_q.pop_front(), 10'h23c);
    chk("word b", asi_serial_peer_inst.got_q.pop_front(), 10'h2c3);
    repeat (40) @(posedge sys_clk);
    // nine-bit word takes its top bit from control
    wr(ADDR_CTLA, 8'h50);
    asi_serial_peer_inst.nbits = 9;
    rd(ADDR_STATUS, d);
    wr(ADDR_DATA, 8'h81);
    wait_words(1);
    chk("nine bit word", asi_serial_peer_inst.got_q.pop_front(), 10'h381);
    repeat (40) @(posedge sys_clk);
    wr(ADDR_CTLA, 8'h00);
    asi_serial_peer_inst.nbits = 8;
    $display("test transmit done");
    // break frames, then mark and quiet line
    wr(ADDR_CTLB, 8'h09);
    wait_words(1);
    chk("break word", asi_serial_peer_inst.got_q.pop_front(), 10'h000);
    wr(ADDR_CTLB, 8'h08);
    repeat (700) @(posedge sys_clk);
    chk("after break", 10'({tx_out, 8'(asi_serial_peer_inst.got_q.size())}), 10'h100);
    // buffer-empty request and cpu mask
    wr(ADDR_CTLB, 8'h88);
    chk("txe irq", 10'(irq), 10'h001);
    cpu_irq_mask <= 1'b1;
    @(posedge sys_clk);
    #1 chk("masked irq", 10'(irq), 10'h000);
    @(posedge sys_clk);
    cpu_irq_mask <= 1'b0;
    // enable toggled mid word: held word dropped, idle frame follows
    rd(ADDR_STATUS, d);
    wr(ADDR_DATA, 8'h69);
    wr(ADDR_DATA, 8'h96);
    wr(ADDR_CTLB, 8'h00);
    wr(ADDR_CTLB, 8'h08);
    wait_words(1);
    chk("toggle word", asi_serial_peer_inst.got_q.pop_front(), 10'h269);
    repeat (700) @(posedge sys_clk);
    chk("held dropped", 10'({tx_out, 8'(asi_serial_peer_inst.got_q.size())}), 10'h100);
    $display("test break and irq done");
    // receive, interrupt, clear, idle line
    wr(ADDR_CTLB, 8'h24);
    asi_serial_peer_inst.send(9'h05a, 8, 1'b1, -1);
    repeat (20) @(posedge sys_clk);
    chk("rx irq", 10'(irq), 10'h001);
    rx_chk(8'h20, 8'h5a);
    chk("rx irq clear", 10'(irq), 10'h000);
    repeat (400) @(posedge sys_clk);
    rd(ADDR_DATA, d);
    rx_chk(8'h10, 8'h5a);
    wr(ADDR_CTLA, 8'h10);
    asi_serial_peer_inst.send(9'h1a5, 9, 1'b1, -1);
    repeat (20) @(posedge sys_clk);
    rd(ADDR_CTLA, d);
    chk("rx ninth", 10'(d), 10'h090);
    rx_chk(8'h20, 8'ha5);
    wr(ADDR_CTLA, 8'h00);
    // overrun keeps the first word
    asi_serial_peer_inst.send(9'h011, 8, 1'b1, -1);
    asi_serial_peer_inst.send(9'h022, 8, 1'b1, -1);
    repeat (20) @(posedge sys_clk);
    rx_chk(8'h28, 8'h11);
    rx_case(9'h033, 1'b1, 3, 8'h24);
    rx_case(9'h000, 1'b0, -1, 8'h22);
    $display("test receive done");
    // each prescale code and divide codes 0 and 1 set the bit length
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CTLB, 8'h00);
      wr(ADDR_BAUD, br_tab[k]);
      wr(ADDR_CTLB, 8'h08);
      rd(ADDR_STATUS, d);
      wr(ADDR_DATA, 8'hff);
      // line looked at on the falling edge, away from the launching edge
      for (lo = 0; lo < 6000 && tx_out !== 1'b0; lo++) @(negedge sys_clk);
      for (lo = 0; lo < 1000 && tx_out === 1'b0; lo++) @(negedge sys_clk);
      chk("start bit length", 10'(lo), 10'(bit_tab[k]));
      repeat (10 * bit_tab[k]) @(posedge sys_clk);
    end
    $display("test baud done");
    finish_test();
  end
endmodule

// [verilog/asi_pkg.sv]
// Purpose: shared constants and types of the async serial interface
// Assumes: 8-bit register port, 25 MHz system clock
// Notes: offsets are small register indexes on the plain port
package asi_pkg;
  // register indexes
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_CTLA = 3'h3;
  localparam logic [2:0] ADDR_CTLB = 3'h4;
  // status_reg bit positions
  localparam int ST_TXE = 7;
  localparam int ST_TXDONE = 6;
  localparam int ST_RXFULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FERR = 1;
  localparam logic [7:0] TX_FLAGS = 8'hc0;
  localparam logic [7:0] RX_FLAGS = 8'h3e;
  localparam logic [7:0] FLAG_MASK = 8'hfe;
  // control_a_reg bit positions
  localparam int CA_RX9 = 7;
  localparam int CA_TX9 = 6;
  localparam int CA_WLEN = 4;
  // control_b_reg bit positions
  localparam int CB_TXE_IE = 7;
  localparam int CB_TXD_IE = 6;
  localparam int CB_RXF_IE = 5;
  localparam int CB_IDLE_IE = 4;
  localparam int CB_TXEN = 3;
  localparam int CB_RXEN = 2;
  localparam int CB_BRK = 0;
  localparam logic [7:0] CTLB_MASK = 8'hfd;
  // baud_select_reg fields
  localparam int BR_PR_LSB = 6;
  localparam int BR_TR_LSB = 3;
  localparam int BR_RR_LSB = 0;
  localparam logic [3:0] PRE_1 = 4'h1;
  localparam logic [3:0] PRE_3 = 4'h3;
  localparam logic [3:0] PRE_4 = 4'h4;
  localparam logic [3:0] PRE_13 = 4'hd;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTLA_RST = 8'h00;
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_HZ_DEF = 1000000000 / CLK_PERIOD_NS;
  localparam int BAUD_MAX_HZ = 250000;
  localparam int BIT_BASE_DIV = 32;
  localparam int OVS = 16;
  localparam int TICK_BASE = BIT_BASE_DIV / OVS;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [10:0] FRAME_ONES = 11'h7ff;
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } asi_bus_s;
  typedef enum logic [3:0] {TX_OFF = 4'b0001, TX_WAIT = 4'b0010, TX_SHIFT = 4'b0100, TX_MARK = 4'b1000} asi_tx_e;
  typedef enum logic [2:0] {RX_OFF = 3'b001, RX_HUNT = 3'b010, RX_BITS = 3'b100} asi_rx_e;
  typedef enum logic [2:0] {K_DATA = 3'b001, K_IDLE = 3'b010, K_BRK = 3'b100} asi_kind_e;
endpackage

// [verilog/asi_top.sv]
// Purpose: full-duplex async serial interface with register port
// Assumes: rx_serial_in synchronous to sys_clk, one-cycle strobes
// Notes: status read data come one cycle after the strobe
`timescale 1ns/1ps

// baud tick at 16 per bit: period 2 * prescale * 2^div cycles
module asi_baud
  import asi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [1:0] pre_code,
  input wire logic [2:0] div_code,
  // tick out
  output logic tick
);
  logic [11:0] cnt_r;
  wire [3:0] pre = (pre_code == 2'h0) ? PRE_1 : (pre_code == 2'h1) ? PRE_3 : (pre_code == 2'h2) ? PRE_4 : PRE_13;
  wire [11:0] lim = (({8'h00, pre} << div_code) * 12'(TICK_BASE)) - 12'h001;
  assign tick = run && (cnt_r == lim);
  // divider counter, held at zero while stopped
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run || tick) cnt_r <= 12'h000;
    else cnt_r <= cnt_r + 12'h001;
  end
endmodule

module asi_top
  import asi_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire asi_bus_s bus_req,
  output logic [7:0] rdata,
  // serial pins
  output logic tx_out,
  output logic tx_oe,
  input wire logic rx_serial_in,
  // cpu interrupt
  input wire logic cpu_irq_mask,
  output logic irq
);
  generate
    if (CLK_HZ / BIT_BASE_DIV < BAUD_MAX_HZ) begin : g_bad_clk
      $error("clock too slow for the top baud rate");
    end
  endgenerate

  logic [7:0] fl_r, snap_r, ctlb_r, baud_r, rdata_r, hold_r, rx_hold_r;
  logic wlen_r, tx9_r, rx9_r, te_d_r, hold_v_r, pend_idle_r, brk_sent_r;
  asi_tx_e tx_st_r, tx_st_nxt;
  asi_kind_e kind_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_bits_r, tx_sub_r;
  asi_rx_e rx_st_r;
  logic [3:0] rx_sub_r, rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [1:0] smp_r;
  logic noisy_r, rx_prev_r, idle_arm_r;
  logic [7:0] idle_cnt_r;

  // register decode
  wire st_acc = (bus_req.rd || bus_req.wr) && bus_req.addr == ADDR_STATUS;
  wire st_rd = bus_req.rd && bus_req.addr == ADDR_STATUS;
  wire dr_rd = bus_req.rd && bus_req.addr == ADDR_DATA;
  wire dr_wr = bus_req.wr && bus_req.addr == ADDR_DATA;
  wire br_wr = bus_req.wr && bus_req.addr == ADDR_BAUD;
  wire ca_wr = bus_req.wr && bus_req.addr == ADDR_CTLA;
  wire cb_wr = bus_req.wr && bus_req.addr == ADDR_CTLB;
  wire te = ctlb_r[CB_TXEN];
  wire re = ctlb_r[CB_RXEN];
  wire send_break_ctl = ctlb_r[CB_BRK];
  wire te_rise = te && !te_d_r;
  wire [3:0] nbits = wlen_r ? FRAME_BITS_9 : FRAME_BITS_8;
  wire [7:0] idle_len = {nbits, 4'h0};
  wire [7:0] ctla_val = {rx9_r, tx9_r, 1'b0, wlen_r, 4'h0};

  // read mux, unmapped reads give zero
  wire [7:0] rd_mux = (bus_req.addr == ADDR_STATUS) ? fl_r :
                      (bus_req.addr == ADDR_DATA) ? rx_hold_r :
                      (bus_req.addr == ADDR_BAUD) ? baud_r :
                      (bus_req.addr == ADDR_CTLA) ? ctla_val :
                      (bus_req.addr == ADDR_CTLB) ? (ctlb_r & CTLB_MASK) : 8'h00;
  assign rdata = rdata_r;

  // control registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctlb_r <= CTLB_RST;
      baud_r <= BAUD_RST;
      wlen_r <= CTLA_RST[CA_WLEN];
      tx9_r <= CTLA_RST[CA_TX9];
      rdata_r <= 8'h00;
      te_d_r <= 1'b0;
    end else begin
      if (cb_wr) ctlb_r <= bus_req.wdata;
      if (br_wr) baud_r <= bus_req.wdata;
      if (ca_wr) wlen_r <= bus_req.wdata[CA_WLEN];
      if (ca_wr) tx9_r <= bus_req.wdata[CA_TX9];
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
      te_d_r <= te;
    end
  end

  // transmit baud and bit timing
  logic tx_tick;
  wire tx_run = (tx_st_r == TX_SHIFT) || (tx_st_r == TX_MARK);
  asi_baud u_tx_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(tx_run),
    .pre_code(baud_r[BR_PR_LSB +: 2]),
    .div_code(baud_r[BR_TR_LSB +: 3]),
    .tick(tx_tick)
  );
  wire bit_end = tx_tick && tx_sub_r == 4'hf;
  wire frame_end = tx_st_r == TX_SHIFT && bit_end && tx_bits_r == 4'h1;
  wire mark_end = tx_st_r == TX_MARK && bit_end;
  wire free = (tx_st_r == TX_OFF) || (tx_st_r == TX_WAIT) || frame_end || mark_end;

  // next frame choice: idle, break, closing mark, then data
  wire pick_idle = pend_idle_r || te_rise;
  wire pick_brk = !pick_idle && send_break_ctl;
  wire pick_mark = !pick_idle && !send_break_ctl && brk_sent_r;
  wire pick_data = !pick_idle && !send_break_ctl && !brk_sent_r && (hold_v_r || dr_wr);
  wire go_frame = te && free && (pick_idle || pick_brk || pick_data);
  wire go_mark = te && free && pick_mark;
  wire take_data = te && free && pick_data;
  wire direct = take_data && !hold_v_r;
  wire [7:0] byte_src = hold_v_r ? hold_r : bus_req.wdata;
  wire ninth = wlen_r ? tx9_r : 1'b1;
  wire [10:0] data_vec = {1'b1, ninth, byte_src, 1'b0};
  wire [10:0] brk_vec = wlen_r ? 11'h000 : 11'h400;
  wire [10:0] frame_vec = pick_idle ? FRAME_ONES : pick_brk ? brk_vec : data_vec;
  wire asi_kind_e kind_nxt = asi_kind_e'(pick_idle ? K_IDLE : pick_brk ? K_BRK : K_DATA);
  wire hold_v_nxt = te && ((hold_v_r && !take_data) || (dr_wr && !direct));
  wire asi_tx_e launch = asi_tx_e'(!te ? TX_OFF : go_mark ? TX_MARK : go_frame ? TX_SHIFT : TX_WAIT);

  // transmit state
  always_comb begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      TX_OFF, TX_WAIT: tx_st_nxt = launch;
      TX_SHIFT: if (frame_end) tx_st_nxt = launch;
      TX_MARK: if (bit_end) tx_st_nxt = launch;
      default: tx_st_nxt = TX_OFF;
    endcase
  end

  // transmit shifter, holding buffer and bookkeeping
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_st_r <= TX_OFF;
      tx_sh_r <= FRAME_ONES;
      tx_bits_r <= 4'h0;
      tx_sub_r <= 4'h0;
      kind_r <= K_IDLE;
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      pend_idle_r <= 1'b0;
      brk_sent_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (dr_wr && !direct) hold_r <= bus_req.wdata;
      hold_v_r <= hold_v_nxt;
      pend_idle_r <= (pend_idle_r || te_rise) && !(go_frame && pick_idle);
      if (go_frame) brk_sent_r <= pick_brk;
      else if (go_mark) brk_sent_r <= 1'b0;
      if (go_frame || go_mark) tx_sub_r <= 4'h0;
      else if (tx_tick) tx_sub_r <= tx_sub_r + 4'h1;
      if (go_frame) begin
        tx_sh_r <= frame_vec;
        tx_bits_r <= nbits;
        kind_r <= kind_nxt;
      end else if (go_mark || tx_st_r != TX_SHIFT) begin
        tx_sh_r <= FRAME_ONES;
      end else if (bit_end) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_bits_r <= tx_bits_r - 4'h1;
      end
    end
  end
  assign tx_out = tx_sh_r[0];
  assign tx_oe = te;

  // receive baud and oversampling
  logic rx_tick;
  asi_baud u_rx_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(re),
    .pre_code(baud_r[BR_PR_LSB +: 2]),
    .div_code(baud_r[BR_RR_LSB +: 3]),
    .tick(rx_tick)
  );
  wire start_seen = rx_st_r == RX_HUNT && rx_tick && rx_prev_r && !rx_serial_in;
  wire at_center = rx_st_r == RX_BITS && rx_tick && rx_sub_r == SMP_C;
  wire vote = (smp_r[0] & smp_r[1]) | (smp_r[0] & rx_serial_in) | (smp_r[1] & rx_serial_in);
  wire disagree = !(smp_r[0] == smp_r[1] && smp_r[1] == rx_serial_in);
  wire false_start = at_center && rx_bit_r == 4'h0 && vote;
  wire char_done = at_center && rx_bit_r == (nbits - 4'h1);
  wire idle_hit = rx_st_r == RX_HUNT && rx_tick && rx_serial_in && idle_arm_r &&
                  idle_cnt_r == (idle_len - 8'h01);
  wire [7:0] rx_byte = wlen_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  wire set_rxf = char_done && !fl_r[ST_RXFULL];
  wire set_ovr = char_done && fl_r[ST_RXFULL];
  wire set_nse = set_rxf && (noisy_r || disagree);
  wire set_fer = set_rxf && !vote;

  // receive state and shifter
  always_ff @(posedge sys_clk) begin
    if (!resetn || !re) begin
      rx_st_r <= asi_rx_e'(re ? RX_HUNT : RX_OFF);
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      smp_r <= 2'h0;
      noisy_r <= 1'b0;
      rx_prev_r <= 1'b0;
      idle_cnt_r <= 8'h00;
      idle_arm_r <= 1'b0;
    end else begin
      if (rx_st_r == RX_OFF) rx_st_r <= RX_HUNT;
      if (rx_tick) rx_prev_r <= rx_serial_in;
      if (rx_tick && rx_st_r == RX_HUNT) idle_cnt_r <= (!rx_serial_in || idle_hit) ? 8'h00 : idle_cnt_r + 8'h01;
      if (char_done) idle_arm_r <= 1'b1;
      else if (idle_hit) idle_arm_r <= 1'b0;
      if (start_seen) begin
        rx_st_r <= RX_BITS;
        rx_sub_r <= 4'h1;
        rx_bit_r <= 4'h0;
        noisy_r <= 1'b0;
      end else if (rx_st_r == RX_BITS && rx_tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
        if (rx_sub_r == SMP_A) smp_r[0] <= rx_serial_in;
        if (rx_sub_r == SMP_B) smp_r[1] <= rx_serial_in;
      end
      if (at_center) begin
        rx_bit_r <= rx_bit_r + 4'h1;
        if (disagree) noisy_r <= 1'b1;
        if (rx_bit_r != 4'h0 && !char_done) rx_sh_r <= {vote, rx_sh_r[8:1]};
        if (false_start || char_done) rx_st_r <= RX_HUNT;
        if (false_start || char_done) idle_cnt_r <= 8'h00;
      end
    end
  end

  // receive holding buffer and ninth bit, untouched on overrun
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_hold_r <= 8'h00;
      rx9_r <= CTLA_RST[CA_RX9];
    end else if (set_rxf) begin
      rx_hold_r <= rx_byte;
      if (wlen_r) rx9_r <= rx_sh_r[8];
    end
  end

  // status flags: set wins over the software clear
  wire [7:0] set_v = {take_data, frame_end, set_rxf, idle_hit, set_ovr, set_nse, set_fer, 1'b0};
  wire [7:0] clr_v = ({8{dr_wr}} & snap_r & TX_FLAGS) | ({8{dr_rd}} & snap_r & RX_FLAGS);
  wire [7:0] fl_nxt = (set_v | (fl_r & ~clr_v)) & (re ? FLAG_MASK : (FLAG_MASK & ~RX_FLAGS));
  wire [7:0] snap_nxt = st_acc ? fl_r : dr_wr ? (snap_r & ~TX_FLAGS) : dr_rd ? (snap_r & ~RX_FLAGS) : snap_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fl_r <= STATUS_RST;
      snap_r <= 8'h00;
    end else begin
      fl_r <= fl_nxt;
      snap_r <= snap_nxt;
    end
  end

  // interrupt request, gated by the cpu mask
  wire irq_src = (fl_r[ST_TXE] && ctlb_r[CB_TXE_IE]) || (fl_r[ST_TXDONE] && ctlb_r[CB_TXD_IE]) ||
                 ((fl_r[ST_RXFULL] || fl_r[ST_OVR]) && ctlb_r[CB_RXF_IE]) ||
                 (fl_r[ST_IDLE] && ctlb_r[CB_IDLE_IE]);
  assign irq = irq_src && !cpu_irq_mask;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_rx_peek;
    st_rd && fl_r[ST_RXFULL] && re;
  endsequence
  sequence s_rx_take;
    dr_rd && !char_done && re;
  endsequence
  sequence s_tx_peek;
    st_rd && fl_r[ST_TXDONE];
  endsequence
  sequence s_tx_take;
    dr_wr && !frame_end;
  endsequence

  // a quiet cycle may sit between the status access and the data access
  a_rx_clear_seq: assert property (s_rx_peek ##[1:2] s_rx_take |=> !fl_r[ST_RXFULL])
    else $error("full flag survived status then data read");
  a_tx_clear_seq: assert property (s_tx_peek ##[1:2] s_tx_take |=> !fl_r[ST_TXDONE])
    else $error("done flag survived status then data write");
  a_late_idle_kept: assert property (dr_rd && !snap_r[ST_IDLE] && fl_r[ST_IDLE] && re |=> fl_r[ST_IDLE])
    else $error("unseen idle flag was cleared");
  a_direct_load: assert property (dr_wr && tx_st_r == TX_WAIT && te && !pick_idle && !send_break_ctl && !brk_sent_r
                                  && !hold_v_r |=> tx_st_r == TX_SHIFT && fl_r[ST_TXE] && !tx_out)
    else $error("quiet write did not start a frame");
  a_hold_write: assert property (dr_wr && tx_st_r == TX_SHIFT && !frame_end && te
                                 |=> hold_v_r && hold_r == $past(bus_req.wdata))
    else $error("busy write not held");
  a_start_low: assert property (tx_st_r == TX_SHIFT && kind_r != K_IDLE && tx_bits_r == nbits |-> !tx_out)
    else $error("start bit not low");
  a_stop_high: assert property (tx_st_r == TX_SHIFT && kind_r == K_DATA && tx_bits_r == 4'h1 |-> tx_out)
    else $error("stop bit not high");
  a_idle_line_high: assert property (te && tx_st_r != TX_SHIFT |-> tx_out && tx_oe)
    else $error("idle line not high");
  a_tc_on_end: assert property (frame_end |=> fl_r[ST_TXDONE])
    else $error("frame end did not set done flag");
  a_irq_masked: assert property (cpu_irq_mask |-> !irq)
    else $error("interrupt through mask");
  a_irq_txe: assert property (fl_r[ST_TXE] && ctlb_r[CB_TXE_IE] && !cpu_irq_mask |-> irq)
    else $error("buffer empty interrupt missing");
  a_rx_load: assert property (char_done && !fl_r[ST_RXFULL] && re
                              |=> fl_r[ST_RXFULL] && rx_hold_r == $past(rx_byte))
    else $error("received char not loaded");
  a_ovr_keeps_buf: assert property (char_done && fl_r[ST_RXFULL] && re |=> fl_r[ST_OVR] && $stable(rx_hold_r))
    else $error("overrun handling wrong");
  a_break_mark: assert property (frame_end && kind_r == K_BRK && !send_break_ctl && te && !pend_idle_r
                                 |=> tx_st_r == TX_MARK ##1 tx_out)
    else $error("no mark bit after break");
  a_enable_idle: assert property (te_rise && free |=> tx_st_r == TX_SHIFT && kind_r == K_IDLE)
    else $error("enable did not send idle frame");
endmodule

// [verilog/asi_top_unused_placeholder_removed.sv]
`timescale 1ns/1ps
// Purpose: none
// Assumes: none
// Notes: none
